// File: hdl/tpsp_defs.svh
// register offsets, field positions, reset values and timing counts of
// the two-pin serial port; assumes a 32-bit apb with byte addresses
`ifndef TPSP_DEFS_SVH
`define TPSP_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TPSP_OFS_CONTROL   8'h00
`define TPSP_OFS_MODE      8'h04
`define TPSP_OFS_IRQ_ON    8'h08
`define TPSP_OFS_IRQ_OFF   8'h0C
`define TPSP_OFS_IRQ_MASK  8'h10
`define TPSP_OFS_STATUS    8'h14
`define TPSP_OFS_RX_HOLD   8'h18
`define TPSP_OFS_TX_HOLD   8'h1C
`define TPSP_OFS_BIT_RATE  8'h20

// ----------------------------------------------------------------
// control_reg command bits
// ----------------------------------------------------------------
`define TPSP_CR_RX_RESET   2
`define TPSP_CR_TX_RESET   3
`define TPSP_CR_RX_ON      4
`define TPSP_CR_RX_OFF     5
`define TPSP_CR_TX_ON      6
`define TPSP_CR_TX_OFF     7
`define TPSP_CR_ERR_CLEAR  8

// ----------------------------------------------------------------
// mode_reg fields and status_reg bits
// ----------------------------------------------------------------
`define TPSP_MR_PAR_LSB    9
`define TPSP_MR_CH_LSB     14
`define TPSP_SR_RX_READY   0
`define TPSP_SR_TX_FREE    1
`define TPSP_SR_OVERRUN    5
`define TPSP_SR_FRAMING    6
`define TPSP_SR_PARITY     7
`define TPSP_SR_TX_IDLE    9
`define TPSP_SR_WIDTH      10

// ----------------------------------------------------------------
// reset values and timing counts in sample ticks
// ----------------------------------------------------------------
`define TPSP_MODE_RESET    5'h00
`define TPSP_DIV_RESET     16'h0000
`define TPSP_START_LOWS    4'h7
`define TPSP_SAMPLE_LAST   4'hF

`endif

// File: hdl/tpsp_pkg.sv
// types shared by the two-pin serial port
// assumes the defs header holds every offset, bit and count; the codes live here
package tpsp_pkg;

    // parity selection codes
    typedef enum logic [2:0] {
        TPSP_PAR_EVEN  = 3'h0,
        TPSP_PAR_ODD   = 3'h1,
        TPSP_PAR_SPACE = 3'h2,
        TPSP_PAR_MARK  = 3'h3,
        TPSP_PAR_NONE  = 3'h4
    } tpsp_par_e;

    // channel test modes
    typedef enum logic [1:0] {
        TPSP_CH_NORMAL = 2'h0,
        TPSP_CH_ECHO   = 2'h1,
        TPSP_CH_LOCAL  = 2'h2,
        TPSP_CH_REMOTE = 2'h3
    } tpsp_ch_e;

    // receiver states, one-hot
    typedef enum logic [2:0] {
        TPSP_RX_IDLE  = 3'b001,
        TPSP_RX_START = 3'b010,
        TPSP_RX_BITS  = 3'b100
    } tpsp_rx_e;

    // transmitter states, one-hot
    typedef enum logic [1:0] {
        TPSP_TX_IDLE = 2'b01,
        TPSP_TX_SEND = 2'b10
    } tpsp_tx_e;

endpackage

// File: hdl/tpsp_top.sv
// two-pin asynchronous serial port with apb register slave
// assumes one clock, synchronous serial input, a zero-or-one wait apb master
`include "tpsp_defs.svh"

// Notes on behaviour
// R1: bit clock is master clock over sixteen times divisor
// R2: zero divisor stops bit clock and both halves
// R3: asynchronous only, 8-bit characters, optional parity
// R4: receiver off after reset, enable starts search
// R5: disable stops idle receiver, else after stop
// R6: receiver reset aborts at once, drops partial char
// R7: start bit needs more than seven low samples
// R8: first sample at 24, then every 16
// R9: full char goes to holding, ready set, read clears
// R10: overrun when char arrives while ready still set
// R11: error flags held until clear command written
// R12: parity mismatch sets parity error with ready
// R13: low stop bit sets framing error with ready
// R14: transmitter off after reset, waits holding write
// R15: disable waits for shift and holding chars
// R16: transmitter reset stops at once
// R17: start, eight data lsb first, parity, stop
// R18: parity odd, even, space, mark or none
// R19: holding free set on enable, cleared while waiting
// R20: fully idle only after last stop bit
// R21: ready flags request dma transfers
// R22: echo forwards input, transmitter keeps running unseen
// R23: local loopback feeds receiver, output held high
// R24: remote loopback joins pins, both halves disabled
// R25: parity codes even 0 odd 1 space 2 mark 3 none 4
// R26: interrupt when any enabled status flag set
module tpsp_top (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_serial_in_line,
    output logic             o_serial_out_line,
    output logic             o_irq,
    output logic             o_dma_rx_req,
    output logic             o_dma_tx_req
);
    import tpsp_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        tpsp_rx_e                rx_st;
        tpsp_tx_e                tx_st;
        logic [15:0]             brg_cnt;
        logic [15:0]             divisor;
        tpsp_par_e               par;
        tpsp_ch_e                channel_test_mode;
        logic [`TPSP_SR_WIDTH-1:0] imr;
        logic                    rx_en;
        logic                    rx_off_pend;
        logic [3:0]              rx_cnt;
        logic [3:0]              rx_idx;
        logic [8:0]              rx_sh;
        logic [7:0]              rhr;
        logic                    rx_ready;
        logic                    overrun;
        logic                    framing;
        logic                    par_err;
        logic                    tx_en;
        logic                    tx_off_pend;
        logic [7:0]              thr;
        logic                    thr_full;
        logic [3:0]              tx_cnt;
        logic [3:0]              tx_idx;
        logic [10:0]             tx_sh;
        logic                    tx_idle;
        logic                    txd;
        logic                    irq;
        logic                    pready;
        logic                    pslverr;
        logic [31:0]             prdata;
        logic                    dma_rx;
        logic                    dma_tx;
    } tpsp_state_s;

    tpsp_state_s st_ff;
    tpsp_state_s nxt_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // parity bit for a character, shared by sender and checker
    function automatic logic par_bit(input logic [7:0] d, input tpsp_par_e p);
        unique case (p)
            TPSP_PAR_EVEN:  par_bit = ^d;     // R25
            TPSP_PAR_ODD:   par_bit = ~^d;    // R25
            TPSP_PAR_SPACE: par_bit = 1'b0;   // R25
            TPSP_PAR_MARK:  par_bit = 1'b1;   // R25
            default:        par_bit = 1'b0;
        endcase
    endfunction

    // address decode used only for the error answer; the read mux decodes the address itself
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= `TPSP_OFS_BIT_RATE);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic                      setup;
        logic                      wr;
        logic                      rd;
        logic                      tick;
        logic                      par_on;
        logic                      rx_in;
        logic                      rx_act;
        logic                      tx_act;
        logic                      tx_line;
        logic                      tx_free;
        logic [3:0]                rx_last;
        logic [3:0]                tx_last;
        logic [`TPSP_SR_WIDTH-1:0] sr;
        logic [31:0]               cr;
        setup   = 1'b0;
        wr      = 1'b0;
        rd      = 1'b0;
        tick    = 1'b0;
        par_on  = 1'b0;
        rx_in   = 1'b1;
        rx_act  = 1'b0;
        tx_act  = 1'b0;
        tx_line = 1'b1;
        tx_free = 1'b0;
        rx_last = 4'h0;
        tx_last = 4'h0;
        sr      = '0;
        cr      = 32'h0000_0000;
        nxt_st  = st_ff;

        // apb: setup cycle registers the answer, access cycle commits it
        setup = i_psel && !i_penable;
        wr    = i_psel && i_penable && st_ff.pready && i_pwrite;
        rd    = i_psel && i_penable && st_ff.pready && !i_pwrite;
        cr    = (wr && i_paddr == `TPSP_OFS_CONTROL) ? i_pwdata : 32'h0000_0000;

        // sixteen ticks per bit, one tick every divisor clocks
        if (st_ff.divisor == `TPSP_DIV_RESET) begin
            nxt_st.brg_cnt = 16'h0000;                       // R2
        end else if (st_ff.brg_cnt == st_ff.divisor - 16'h0001) begin
            nxt_st.brg_cnt = 16'h0000;
            tick           = 1'b1;                           // R1
        end else begin
            nxt_st.brg_cnt = st_ff.brg_cnt + 16'h0001;       // R1
        end

        par_on  = (st_ff.par != TPSP_PAR_NONE);              // R18
        rx_last = par_on ? 4'h9 : 4'h8;
        tx_last = par_on ? 4'hA : 4'h9;
        // remote loopback leaves both halves without effect
        rx_act  = st_ff.rx_en && (st_ff.channel_test_mode != TPSP_CH_REMOTE);  // R24
        tx_act  = st_ff.tx_en && (st_ff.channel_test_mode != TPSP_CH_REMOTE);  // R24
        tx_line = (st_ff.tx_st == TPSP_TX_SEND) ? st_ff.tx_sh[0] : 1'b1;
        // local loopback ignores the pin and listens to the transmitter
        rx_in   = (st_ff.channel_test_mode == TPSP_CH_LOCAL) ? tx_line : i_serial_in_line;  // R23

        // --------------------
        // receiver
        // --------------------
        if (cr[`TPSP_CR_RX_OFF]) begin
            if (st_ff.rx_st == TPSP_RX_IDLE) begin
                nxt_st.rx_en = 1'b0;                         // R5
            end else begin
                nxt_st.rx_off_pend = 1'b1;                   // R5
            end
        end else if (cr[`TPSP_CR_RX_ON]) begin
            nxt_st.rx_en       = 1'b1;                       // R4
            nxt_st.rx_off_pend = 1'b0;
        end

        // clears act first, so a flag set in this same cycle wins
        if (rd && i_paddr == `TPSP_OFS_RX_HOLD) begin
            nxt_st.rx_ready = 1'b0;  // R9
        end
        if (cr[`TPSP_CR_ERR_CLEAR]) begin
            nxt_st.overrun = 1'b0;  // R11
            nxt_st.framing = 1'b0;  // R11
            nxt_st.par_err = 1'b0;  // R11
        end
        if (rx_act && tick) begin
            unique case (st_ff.rx_st)
                TPSP_RX_IDLE: begin
                    if (!rx_in) begin
                        nxt_st.rx_st  = TPSP_RX_START;
                        nxt_st.rx_cnt = 4'h1;
                    end
                end
                TPSP_RX_START: begin
                    // a short space is a glitch, not a start bit
                    if (rx_in) begin
                        nxt_st.rx_st = TPSP_RX_IDLE;         // R7
                    end else if (st_ff.rx_cnt == `TPSP_START_LOWS) begin
                        nxt_st.rx_st  = TPSP_RX_BITS;        // R7
                        nxt_st.rx_cnt = 4'h0;
                        nxt_st.rx_idx = 4'h0;
                    end else begin
                        nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
                    end
                end
                TPSP_RX_BITS: begin
                    nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;     // R8
                    if (st_ff.rx_cnt == `TPSP_SAMPLE_LAST) begin
                        nxt_st.rx_idx = st_ff.rx_idx + 4'h1; // R8
                        if (st_ff.rx_idx != rx_last) begin
                            nxt_st.rx_sh[st_ff.rx_idx] = rx_in;  // R3
                        end else begin
                            // stop bit sampled: hand the character over
                            nxt_st.rx_st    = TPSP_RX_IDLE;
                            nxt_st.rhr      = st_ff.rx_sh[7:0];  // R9
                            nxt_st.rx_ready = 1'b1;              // R9
                            if (st_ff.rx_ready) begin
                                nxt_st.overrun = 1'b1;           // R10
                            end
                            if (par_on && st_ff.rx_sh[8]
                                    != par_bit(st_ff.rx_sh[7:0], st_ff.par)) begin
                                nxt_st.par_err = 1'b1;           // R12
                            end
                            if (!rx_in) begin
                                nxt_st.framing = 1'b1;           // R13
                            end
                            if (st_ff.rx_off_pend) begin
                                nxt_st.rx_en       = 1'b0;       // R5
                                nxt_st.rx_off_pend = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    nxt_st.rx_st = TPSP_RX_IDLE;
                end
            endcase
        end

        if (cr[`TPSP_CR_RX_RESET]) begin
            nxt_st.rx_st       = TPSP_RX_IDLE;               // R6
            nxt_st.rx_en       = 1'b0;                       // R6
            nxt_st.rx_off_pend = 1'b0;
        end

        // --------------------
        // transmitter
        // --------------------
        if (cr[`TPSP_CR_TX_OFF]) begin
            nxt_st.tx_off_pend = 1'b1;                       // R15
        end else if (cr[`TPSP_CR_TX_ON]) begin
            nxt_st.tx_en       = 1'b1;                       // R14
            nxt_st.tx_off_pend = 1'b0;
        end

        // holding writes only count while the transmitter is enabled
        if (wr && i_paddr == `TPSP_OFS_TX_HOLD && st_ff.tx_en) begin
            nxt_st.thr      = i_pwdata[7:0];                 // R14
            nxt_st.thr_full = 1'b1;                          // R19
        end

        unique case (st_ff.tx_st)
            TPSP_TX_IDLE: begin
                if (tx_act && st_ff.thr_full && st_ff.divisor != `TPSP_DIV_RESET) begin
                    nxt_st.tx_st    = TPSP_TX_SEND;          // R14
                    nxt_st.tx_sh    = {1'b1, par_on ? par_bit(st_ff.thr, st_ff.par)
                                       : 1'b1, st_ff.thr, 1'b0};  // R17
                    nxt_st.thr_full = 1'b0;                  // R19
                    nxt_st.tx_cnt   = 4'h0;
                    nxt_st.tx_idx   = 4'h0;
                end else if (st_ff.tx_off_pend && !st_ff.thr_full) begin
                    nxt_st.tx_en       = 1'b0;               // R15
                    nxt_st.tx_off_pend = 1'b0;
                end
            end
            TPSP_TX_SEND: begin
                if (tick && tx_act) begin
                    nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;     // R17
                    if (st_ff.tx_cnt == `TPSP_SAMPLE_LAST) begin
                        nxt_st.tx_idx = st_ff.tx_idx + 4'h1;
                        nxt_st.tx_sh  = {1'b1, st_ff.tx_sh[10:1]};  // R17
                        if (st_ff.tx_idx == tx_last) begin
                            nxt_st.tx_st = TPSP_TX_IDLE;     // R20
                        end
                    end
                end
            end
            default: begin
                nxt_st.tx_st = TPSP_TX_IDLE;
            end
        endcase

        if (cr[`TPSP_CR_TX_RESET]) begin
            nxt_st.tx_st       = TPSP_TX_IDLE;               // R16
            nxt_st.tx_en       = 1'b0;                       // R16
            nxt_st.tx_off_pend = 1'b0;
            nxt_st.thr_full    = 1'b0;
        end

        // flags follow the transmitter's next state
        tx_free        = nxt_st.tx_en && !nxt_st.thr_full;   // R19
        nxt_st.tx_idle = tx_free && nxt_st.tx_st == TPSP_TX_IDLE;  // R20

        // --------------------
        // output line by channel mode
        // --------------------
        unique case (st_ff.channel_test_mode)
            TPSP_CH_NORMAL: nxt_st.txd = tx_line;
            TPSP_CH_ECHO:   nxt_st.txd = i_serial_in_line;   // R22
            TPSP_CH_LOCAL:  nxt_st.txd = 1'b1;               // R23
            TPSP_CH_REMOTE: nxt_st.txd = i_serial_in_line;   // R24
        endcase

        // --------------------
        // registers written by software
        // --------------------
        if (wr && i_paddr == `TPSP_OFS_MODE) begin
            nxt_st.par    = tpsp_par_e'(i_pwdata[`TPSP_MR_PAR_LSB +: 3]);  // R25
            nxt_st.channel_test_mode = tpsp_ch_e'(i_pwdata[`TPSP_MR_CH_LSB +: 2]);
        end
        if (wr && i_paddr == `TPSP_OFS_BIT_RATE) begin
            nxt_st.divisor = i_pwdata[15:0];                 // R1
        end
        if (wr && i_paddr == `TPSP_OFS_IRQ_ON) begin
            nxt_st.imr = st_ff.imr | i_pwdata[`TPSP_SR_WIDTH-1:0];
        end
        if (wr && i_paddr == `TPSP_OFS_IRQ_OFF) begin
            nxt_st.imr = st_ff.imr & ~i_pwdata[`TPSP_SR_WIDTH-1:0];
        end

        // --------------------
        // status, interrupt, dma requests
        // --------------------
        sr[`TPSP_SR_RX_READY] = st_ff.rx_ready;
        sr[`TPSP_SR_TX_FREE]  = st_ff.tx_en && !st_ff.thr_full;  // R19
        sr[`TPSP_SR_OVERRUN]  = st_ff.overrun;
        sr[`TPSP_SR_FRAMING]  = st_ff.framing;
        sr[`TPSP_SR_PARITY]   = st_ff.par_err;
        sr[`TPSP_SR_TX_IDLE]  = st_ff.tx_idle;
        nxt_st.irq    = |(sr & st_ff.imr);                   // R26
        // requests drop as soon as the serving access is taken
        nxt_st.dma_rx = nxt_st.rx_ready;                     // R21
        nxt_st.dma_tx = tx_free;                             // R21

        // answer prepared in setup, held ready for the access cycle
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup && !is_mapped(i_paddr);
        nxt_st.prdata  = 32'h0000_0000;
        if (setup && !i_pwrite) begin
            unique case (i_paddr)
                `TPSP_OFS_MODE:     nxt_st.prdata = {16'h0000, st_ff.channel_test_mode, 2'b00,
                                                     st_ff.par, 9'h000};
                `TPSP_OFS_IRQ_MASK: nxt_st.prdata = {22'h000000, st_ff.imr};
                `TPSP_OFS_STATUS:   nxt_st.prdata = {22'h000000, sr};
                `TPSP_OFS_RX_HOLD:  nxt_st.prdata = {24'h000000, st_ff.rhr};
                `TPSP_OFS_BIT_RATE: nxt_st.prdata = {16'h0000, st_ff.divisor};
                default:            nxt_st.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff             <= '0;
            st_ff.rx_st       <= TPSP_RX_IDLE;
            st_ff.tx_st       <= TPSP_TX_IDLE;
            st_ff.par         <= TPSP_PAR_EVEN;
            st_ff.channel_test_mode      <= TPSP_CH_NORMAL;
            st_ff.divisor     <= `TPSP_DIV_RESET;
            st_ff.txd         <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs come straight from the state register
    assign o_prdata          = st_ff.prdata;
    assign o_pready          = st_ff.pready;
    assign o_pslverr         = st_ff.pslverr;
    assign o_serial_out_line = st_ff.txd;
    assign o_irq             = st_ff.irq;
    assign o_dma_rx_req      = st_ff.dma_rx;
    assign o_dma_tx_req      = st_ff.dma_tx;

endmodule

// File: testbench/tpsp_properties.sv
// checker for the serial port top: apb timing, test modes, error flags
// assumes it is bound to tpsp_top and sees only its ports
module tpsp_properties (
    input wire logic        i_mclk, i_reset_n, i_psel, i_penable, i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata, o_prdata,
    input wire logic        o_pready, o_pslverr, i_serial_in_line, o_serial_out_line,
    input wire logic        o_dma_rx_req, o_dma_tx_req
);
    logic [1:0] ch_ff;  // channel mode last written
    logic [2:0] err_ff; // error flags seen at the last status read, zeroed by a clear command
    logic       wr_ok;
    logic       rd_st;
    assign wr_ok = i_psel && i_penable && o_pready && i_pwrite;
    assign rd_st = i_psel && i_penable && o_pready && !i_pwrite && i_paddr == 8'h14;
    // shadows follow committed writes and status reads so the checks need no internal state
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ch_ff <= 2'h0;
            err_ff <= 3'h0;
        end else begin
            if (wr_ok && i_paddr == 8'h04) ch_ff <= i_pwdata[15:14];
            if (wr_ok && i_paddr == 8'h00 && i_pwdata[8]) err_ff <= 3'h0;
            else if (rd_st) err_ff <= o_prdata[7:5];
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready too long");
    a_unmapped_error: assert property (o_pready && i_paddr > 8'h20 |-> o_pslverr)
        else $error("unmapped without error");
    a_idle_rdata_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("rdata");
    a_reset_quiet: assert property ($rose(i_reset_n) |-> o_serial_out_line &&
        !o_dma_tx_req && !o_dma_rx_req) else $error("active after reset");
    a_local_out_high: assert property (ch_ff == 2'h2 && $past(ch_ff) == 2'h2
        |-> o_serial_out_line) else $error("out low in local loopback");
    a_echo_copies_in: assert property (ch_ff[0] && $past(ch_ff[0])
        |-> o_serial_out_line == $past(i_serial_in_line)) else $error("echo");
    a_errors_kept: assert property (rd_st |-> (o_prdata[7:5] & err_ff) == err_ff)
        else $error("error flag lost");
    c_unmapped: cover property (o_pslverr);
    c_overrun: cover property (rd_st && o_prdata[5]);
    c_rx_dma: cover property (o_dma_rx_req);
endmodule
bind tpsp_top tpsp_properties tpsp_properties_i (.*);

// File: testbench/tpsp_remote.sv
// remote serial device: sends frames on demand, captures frames it hears
// assumes 16 clocks a bit, so the bench programs a divisor of one
module tpsp_remote (
    input  wire logic i_mclk,
    input  wire logic i_line,
    output logic      o_line
);
    timeunit 1ns;
    timeprecision 100ps;
    int         nrx = 0; // frames captured
    logic [8:0] got;     // data and the bit after it
    initial o_line = 1'b1;
    // start low, data lsb first, optional parity, stop, then idle high
    task automatic send(input logic [8:0] v, input logic stp, input logic pon);
        logic [10:0] f;
        f = pon ? {1'b1, stp, v, 1'b0} : {2'b11, stp, v[7:0], 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge i_mclk) o_line <= f[i];
            repeat (10) @(posedge i_mclk);
            if (i == 10 - !pon) o_line <= 1'b1; // short low stop, no false start
            repeat (5) @(posedge i_mclk);
        end
    endtask
    // mid-bit sampling; the ninth sample is parity, or stop without parity
    always begin
        @(negedge i_line);
        repeat (8) @(posedge i_mclk);
        for (int b = 0; b < 9; b++) begin
            repeat (16) @(posedge i_mclk);
            got[b] = i_line;
        end
        nrx++;
    end
endmodule

// File: testbench/tpsp_top_tb.sv
// self-checking bench for tpsp_top over apb with a remote serial device
// assumes zero-wait apb answers and a divisor of one
module tpsp_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, sin, sout, dreq_rx, dreq_tx, irq;
    int          error_cnt = 0, check_count = 0, cyc = 0, n;
    initial forever #4 clk = ~clk;
    tpsp_top tpsp_top_i (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_serial_in_line(sin),
        .o_serial_out_line(sout), .o_irq(irq), .o_dma_rx_req(dreq_rx), .o_dma_tx_req(dreq_tx));
    tpsp_remote tpsp_remote_i (.i_mclk(clk), .i_line(sout), .o_line(sin));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic wait_frames(input int k);
        for (int i = 0; i < 900 && tpsp_remote_i.nrx < n + k; i++) @(posedge clk);
        n = tpsp_remote_i.nrx;
    endtask
    function automatic logic par(input int p, input logic [7:0] d);
        return p == 0 ? ^d : p == 1 ? ~^d : p != 2;
    endfunction
    task automatic t_regs;
        bus(0, 8'h04, 0); chk(rd, 0, "mode reset");
        bus(0, 8'h20, 0); chk(rd, 0, "divisor reset");
        bus(1, 8'h20, 1); bus(0, 8'h20, 0); chk(rd, 1, "divisor");
        bus(0, 8'h40, 0); chk(err, 1, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_rx;
        bus(1, 8'h00, 32'h10); bus(1, 8'h08, 1);
        tpsp_remote_i.send({par(0, 8'h5A), 8'h5A}, 1, 1);
        for (int i = 0; i < 400 && dreq_rx !== 1'b1; i++) @(posedge clk);
        chk(dreq_rx, 1, "rx dma");
        chk(irq, 1, "irq");
        bus(0, 8'h14, 0); chk(rd & 32'hE1, 32'h01, "rx status");
        bus(0, 8'h18, 0); chk(rd[7:0], 8'h5A, "rx data");
        bus(0, 8'h14, 0); chk(rd & 32'h1, 0, "ready cleared");
        tpsp_remote_i.send({~par(0, 8'h81), 8'h81}, 0, 1);
        bus(0, 8'h14, 0); chk(rd & 32'hE1, 32'hC1, "errors");
        tpsp_remote_i.send({par(0, 8'h42), 8'h42}, 1, 1);
        bus(0, 8'h14, 0); chk(rd & 32'hE1, 32'hE1, "overrun");
        bus(1, 8'h00, 32'h100); bus(0, 8'h14, 0); chk(rd & 32'hE0, 0, "cleared");
        bus(0, 8'h18, 0); chk(rd[7:0], 8'h42, "newest");
        $display("test rx done");
    endtask
    task automatic t_tx;
        bus(1, 8'h00, 32'h40); n = tpsp_remote_i.nrx;
        for (int p = 0; p < 5; p++) begin
            bus(1, 8'h04, p << 9); bus(1, 8'h1C, 8'hA5 + p); wait_frames(1);
            chk(tpsp_remote_i.got, {par(p, 8'hA5 + p), 8'(8'hA5 + p)}, "tx frame");
        end
        repeat (16) @(posedge clk);
        bus(0, 8'h14, 0); chk(rd & 32'h202, 32'h202, "tx idle");
        bus(1, 8'h1C, 8'h11); bus(1, 8'h1C, 8'h77);
        bus(0, 8'h14, 0); chk(rd & 32'h202, 0, "holding full");
        chk(dreq_tx, 0, "tx dma");
        bus(1, 8'h00, 32'h80); wait_frames(2);
        chk(tpsp_remote_i.got, 9'h177, "both sent");
        $display("test tx done");
    endtask
    task automatic t_modes;
        bus(1, 8'h00, 32'h50); bus(1, 8'h04, 32'h8800); bus(1, 8'h1C, 8'h3C);
        for (int i = 0; i < 400 && dreq_rx !== 1'b1; i++) @(posedge clk);
        bus(0, 8'h18, 0); chk(rd[7:0], 8'h3C, "local loop");
        bus(1, 8'h04, 32'h4800); tpsp_remote_i.send(9'h099, 1, 0); wait_frames(1);
        chk(tpsp_remote_i.got, 9'h199, "echo");
        $display("test modes done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_rx;
        t_tx;
        t_modes;
        print_verdict;
    end
endmodule
